// ### verilog/spmrc_pkg.sv
/*
 * Constants and types for the self-programming host sequencer: control
 * register field positions, command codes, pointer addresses, timing.
 * Assumes a 20 MHz core clock shared with the programmed device.
 */
package spmrc_pkg;

	// ------------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------------
	localparam int SPMRC_SPM_EN_BIT   = 0;
	localparam int SPMRC_RWW_BUSY_BIT = 6;

	localparam logic [7:0] SPMRC_CODE_ERASE  = 8'h03;
	localparam logic [7:0] SPMRC_CODE_LOAD   = 8'h01;
	localparam logic [7:0] SPMRC_CODE_WRITE  = 8'h05;
	localparam logic [7:0] SPMRC_CODE_LOCKWR = 8'h09;
	localparam logic [7:0] SPMRC_CODE_RWWEN  = 8'h11;
	localparam logic [7:0] SPMRC_CODE_FLREAD = 8'h09;
	localparam logic [7:0] SPMRC_CODE_SIGNATURE_READ_SELECT  = 8'h21;

	// ------------------------------------------------------------------
	// pointer values and readback masks
	// ------------------------------------------------------------------
	localparam logic [15:0] SPMRC_PTR_FUSE_LO  = 16'h0000;
	localparam logic [15:0] SPMRC_PTR_LOCK     = 16'h0001;
	localparam logic [15:0] SPMRC_PTR_FUSE_EXT = 16'h0002;
	localparam logic [15:0] SPMRC_PTR_FUSE_HI  = 16'h0003;
	localparam logic [15:0] SPMRC_SIG_ID1      = 16'h0000;
	localparam logic [15:0] SPMRC_SIG_CAL      = 16'h0001;
	localparam logic [15:0] SPMRC_SIG_ID2      = 16'h0002;
	localparam logic [15:0] SPMRC_SIG_ID3      = 16'h0004;
	localparam logic [15:0] SPMRC_SIG_SER_LO   = 16'h000E;
	localparam logic [15:0] SPMRC_SIG_SER_HI   = 16'h0018;
	// unused bits forced to one (unprogrammed)
	localparam logic [7:0]  SPMRC_LOCK_UNUSED  = 8'hC0;
	localparam logic [7:0]  SPMRC_EXT_UNUSED   = 8'hF8;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int SPMRC_CLK_HZ      = 20000000;
	localparam int SPMRC_T_MAX_US    = 4500;
	localparam int SPMRC_MAX_CYC     = SPMRC_CLK_HZ / 1000000 * SPMRC_T_MAX_US;
	localparam int SPMRC_TMR_W       = 17;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		SPMRC_OP_ERASE    = 4'h0,
		SPMRC_OP_LOAD     = 4'h1,
		SPMRC_OP_WRITE    = 4'h2,
		SPMRC_OP_LOCK_WR  = 4'h3,
		SPMRC_OP_RWW_EN   = 4'h4,
		SPMRC_OP_LOCK_RD  = 4'h5,
		SPMRC_OP_FUSE_LO  = 4'h6,
		SPMRC_OP_FUSE_HI  = 4'h7,
		SPMRC_OP_FUSE_EXT = 4'h8,
		SPMRC_OP_SIG_RD   = 4'h9
	} spmrc_op_t;

	typedef struct packed {
		spmrc_op_t   op;
		logic [15:0] addr;
		logic [15:0] data;
	} spmrc_cmd_t;

	typedef struct packed {
		logic [7:0] data;
		logic       err;
	} spmrc_rsp_t;

endpackage : spmrc_pkg

// ### verilog/spmrc_timer.sv
/*
 * Down-counting watchdog used while polling device status.
 * Assumes load and the count come from the same clock domain.
 */
`timescale 1ns/10ps
module spmrc_timer (
	input  wire logic                            core_clk,
	input  wire logic                            rstn,
	input  wire logic                            load,
	input  wire logic [spmrc_pkg::SPMRC_TMR_W-1:0] count,
	output logic                                 expired
);
	import spmrc_pkg::*;

	logic [SPMRC_TMR_W-1:0] cnt_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			cnt_r <= '0;
		else if (load)
			cnt_r <= count;
		else if (cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
	end

	// no load term here: load is decoded from the state that reads this,
	// and feeding it back would close a zero-delay loop
	assign expired = (cnt_r == '0);

endmodule : spmrc_timer

// ### verilog/spmrc_host.sv
/*
 * Host sequencer that drives a self-programming flash block: it waits
 * for the previous command, waits out eeprom writes, writes the control
 * register, fires the store or load strobe, and returns readback bytes.
 * Assumes the device shares core_clk and answers a load one cycle later.
 */
// Contract
// - host checks eeprom busy clear before writing the control register.
// - lock read: pointer 0x0001, select bits set, load within three cycles.
// - pointer 0x0000 with fuse select returns low fuse byte.
// - pointer 0x0003 with fuse select returns high fuse byte.
// - pointer 0x0002 returns extended fuse, only bits 2..0 used.
// - signature read: address in pointer, signature select, load within three.
// - host treats other signature addresses as reserved.
// - host polls until enable bit clears before a new command.
// - host holds interrupts off around control write and store.
// - host checks rww busy and issues re-enable before reading application.
// - codes erase X0000011, load 00000001, write X0000101, store within four.
`timescale 1ns/10ps
module spmrc_host #(
	parameter int MAX_CYC = spmrc_pkg::SPMRC_MAX_CYC
) (
	input  wire logic                  core_clk,
	input  wire logic                  rstn,
	input  wire logic                  cmd_valid,
	output logic                       cmd_ready,
	input  wire spmrc_pkg::spmrc_cmd_t cmd,
	output logic                       rsp_valid,
	output spmrc_pkg::spmrc_rsp_t      rsp,
	output logic                       irq_hold,
	output logic                       dev_ctrl_wr,
	output logic [7:0]                 dev_ctrl_wdata,
	input  wire logic [7:0]            dev_ctrl_rdata,
	input  wire logic                  dev_eeprom_busy,
	output logic [15:0]                dev_ptr,
	output logic [15:0]                dev_wdata,
	output logic                       dev_store,
	output logic                       dev_load,
	input  wire logic [7:0]            dev_load_data
);
	import spmrc_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_WAIT_SPM  = 4'b0001,
		ST_WAIT_EE   = 4'b0010,
		ST_ARM       = 4'b0011,
		ST_ISSUE     = 4'b0100,
		ST_CAPTURE   = 4'b0101,
		ST_WAIT_DONE = 4'b0110,
		ST_RWW_CHK   = 4'b0111,
		ST_DONE      = 4'b1000
	} spmrc_state_t;

	spmrc_state_t state_r, state_nxt;
	spmrc_op_t    op_r, op_nxt;
	logic [7:0]   code_r, code_nxt;
	logic [15:0]  ptr_r, ptr_nxt;
	logic [15:0]  wdata_r;
	logic [7:0]   rdata_r, rdata_nxt;
	logic         err_r, err_nxt;
	logic         rww_done_r, rww_done_nxt;

	// ------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------
	wire spm_busy   = dev_ctrl_rdata[SPMRC_SPM_EN_BIT];
	wire rww_busy   = dev_ctrl_rdata[SPMRC_RWW_BUSY_BIT];
	wire is_read    = (cmd.op == SPMRC_OP_LOCK_RD) ||
	                  (cmd.op == SPMRC_OP_FUSE_LO) ||
	                  (cmd.op == SPMRC_OP_FUSE_HI) ||
	                  (cmd.op == SPMRC_OP_FUSE_EXT) ||
	                  (cmd.op == SPMRC_OP_SIG_RD);
	wire op_is_read = (op_r == SPMRC_OP_LOCK_RD) ||
	                  (op_r == SPMRC_OP_FUSE_LO) ||
	                  (op_r == SPMRC_OP_FUSE_HI) ||
	                  (op_r == SPMRC_OP_FUSE_EXT) ||
	                  (op_r == SPMRC_OP_SIG_RD);
	wire op_long    = (op_r == SPMRC_OP_ERASE) ||
	                  (op_r == SPMRC_OP_WRITE);
	wire sig_ok     = (cmd.addr == SPMRC_SIG_ID1) ||
	                  (cmd.addr == SPMRC_SIG_CAL) ||
	                  (cmd.addr == SPMRC_SIG_ID2) ||
	                  (cmd.addr == SPMRC_SIG_ID3) ||
	                  ((cmd.addr >= SPMRC_SIG_SER_LO) &&
	                   (cmd.addr <= SPMRC_SIG_SER_HI));
	wire sig_bad    = (cmd.op == SPMRC_OP_SIG_RD) && !sig_ok;
	wire timer_load = (state_r != state_nxt);
	wire timed_out;

	// programmed reads zero, so unused bits are shown as unprogrammed
	wire [7:0] load_fixed =
		(op_r == SPMRC_OP_LOCK_RD)  ? (dev_load_data | SPMRC_LOCK_UNUSED) :
		(op_r == SPMRC_OP_FUSE_EXT) ? (dev_load_data | SPMRC_EXT_UNUSED) :
		dev_load_data;

	spmrc_timer u_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.load     (timer_load),
		.count    (SPMRC_TMR_W'(MAX_CYC)),
		.expired  (timed_out)
	);

	// ------------------------------------------------------------------
	// command code and pointer per operation
	// ------------------------------------------------------------------
	always_comb begin
		code_nxt = code_r;
		ptr_nxt  = ptr_r;
		if (state_r == ST_IDLE && cmd_valid) begin
			ptr_nxt = cmd.addr;
			case (cmd.op)
			SPMRC_OP_ERASE:    code_nxt = SPMRC_CODE_ERASE;
			SPMRC_OP_LOAD:     code_nxt = SPMRC_CODE_LOAD;
			SPMRC_OP_WRITE:    code_nxt = SPMRC_CODE_WRITE;
			SPMRC_OP_LOCK_WR: begin
				code_nxt = SPMRC_CODE_LOCKWR;
				ptr_nxt  = SPMRC_PTR_LOCK;
			end
			SPMRC_OP_RWW_EN:   code_nxt = SPMRC_CODE_RWWEN;
			SPMRC_OP_LOCK_RD: begin
				code_nxt = SPMRC_CODE_FLREAD;
				ptr_nxt  = SPMRC_PTR_LOCK;
			end
			SPMRC_OP_FUSE_LO: begin
				code_nxt = SPMRC_CODE_FLREAD;
				ptr_nxt  = SPMRC_PTR_FUSE_LO;
			end
			SPMRC_OP_FUSE_HI: begin
				code_nxt = SPMRC_CODE_FLREAD;
				ptr_nxt  = SPMRC_PTR_FUSE_HI;
			end
			SPMRC_OP_FUSE_EXT: begin
				code_nxt = SPMRC_CODE_FLREAD;
				ptr_nxt  = SPMRC_PTR_FUSE_EXT;
			end
			SPMRC_OP_SIG_RD:   code_nxt = SPMRC_CODE_SIGNATURE_READ_SELECT;
			default:           code_nxt = SPMRC_CODE_LOAD;
			endcase
		end else if (state_r == ST_RWW_CHK && rww_busy) begin
			code_nxt = SPMRC_CODE_RWWEN;
		end
	end

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------
	always_comb begin
		state_nxt    = state_r;
		op_nxt       = op_r;
		rdata_nxt    = rdata_r;
		err_nxt      = err_r;
		rww_done_nxt = rww_done_r;
		case (state_r)
		ST_IDLE: begin
			if (cmd_valid) begin
				op_nxt       = cmd.op;
				rdata_nxt    = '0;
				rww_done_nxt = 1'b0;
				err_nxt      = sig_bad;
				state_nxt    = sig_bad ? ST_DONE : ST_WAIT_SPM;
			end
		end
		ST_WAIT_SPM: begin
			if (!spm_busy)
				state_nxt = ST_WAIT_EE;
			else if (timed_out) begin
				err_nxt   = 1'b1;
				state_nxt = ST_DONE;
			end
		end
		ST_WAIT_EE: begin
			// a readback armed now would return nothing
			if (!dev_eeprom_busy)
				state_nxt = ST_ARM;
			else if (timed_out) begin
				err_nxt   = 1'b1;
				state_nxt = ST_DONE;
			end
		end
		ST_ARM:       state_nxt = ST_ISSUE;
		ST_ISSUE:     state_nxt = op_is_read ? ST_CAPTURE : ST_WAIT_DONE;
		ST_CAPTURE: begin
			rdata_nxt = load_fixed;
			state_nxt = ST_DONE;
		end
		ST_WAIT_DONE: begin
			if (!spm_busy)
				state_nxt = (op_long && !rww_done_r) ? ST_RWW_CHK : ST_DONE;
			else if (timed_out) begin
				err_nxt   = 1'b1;
				state_nxt = ST_DONE;
			end
		end
		ST_RWW_CHK: begin
			if (rww_busy) begin
				rww_done_nxt = 1'b1;
				state_nxt    = ST_WAIT_SPM;
			end else
				state_nxt = ST_DONE;
		end
		ST_DONE:      state_nxt = ST_IDLE;
		default:      state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_r    <= ST_IDLE;
			op_r       <= SPMRC_OP_LOAD;
			code_r     <= '0;
			ptr_r      <= '0;
			wdata_r    <= '0;
			rdata_r    <= '0;
			err_r      <= 1'b0;
			rww_done_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			op_r       <= op_nxt;
			code_r     <= code_nxt;
			ptr_r      <= ptr_nxt;
			rdata_r    <= rdata_nxt;
			err_r      <= err_nxt;
			rww_done_r <= rww_done_nxt;
			if (state_r == ST_IDLE && cmd_valid)
				wdata_r <= cmd.data;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// strobe lands one cycle after the control write, inside the window
	assign cmd_ready      = (state_r == ST_IDLE);
	assign dev_ctrl_wr    = (state_r == ST_ARM);
	assign dev_ctrl_wdata = code_r;
	assign dev_ptr        = ptr_r;
	assign dev_wdata      = wdata_r;
	assign dev_store      = (state_r == ST_ISSUE) && !op_is_read;
	assign dev_load       = (state_r == ST_ISSUE) && op_is_read;
	assign irq_hold       = (state_r == ST_ARM) ||
	                        (state_r == ST_ISSUE);
	assign rsp_valid      = (state_r == ST_DONE);
	assign rsp.data       = rdata_r;
	assign rsp.err        = err_r;

endmodule : spmrc_host

// ### dv/spmrc_host_properties.sv
/*
 * Port checker for the self-programming host sequencer.
 * Assumes one clock domain and the device link timing of the hand-over.
 */
`timescale 1ns/10ps
module spmrc_host_properties #(
	parameter int MAX_CYC = 50
) (
	input wire logic                  core_clk,
	input wire logic                  rstn,
	input wire logic                  rsp_valid,
	input wire spmrc_pkg::spmrc_rsp_t rsp,
	input wire logic                  irq_hold,
	input wire logic                  dev_ctrl_wr,
	input wire logic [7:0]            dev_ctrl_wdata,
	input wire logic [7:0]            dev_ctrl_rdata,
	input wire logic                  dev_eeprom_busy,
	input wire logic [15:0]           dev_ptr,
	input wire logic                  dev_store,
	input wire logic                  dev_load,
	input wire logic [7:0]            dev_load_data
);
	import spmrc_pkg::*;
	// ------
	// link sequences and rules
	// ------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_fl_load;
		dev_load && dev_ctrl_wdata == SPMRC_CODE_FLREAD;
	endsequence
	sequence s_answer;
		##2 rsp_valid && !rsp.err;
	endsequence
	property p_arm;
		dev_ctrl_wr |=> dev_store || dev_load;
	endproperty
	property p_ee;
		dev_ctrl_wr |-> !$past(dev_eeprom_busy);
	endproperty
	property p_spm;
		dev_ctrl_wr |-> !$past(dev_ctrl_rdata[0]);
	endproperty
	property p_irq;
		dev_ctrl_wr |-> irq_hold ##1 irq_hold;
	endproperty
	property p_fl_ptr;
		s_fl_load |-> dev_ptr <= 16'h0003;
	endproperty
	property p_lock;
		s_fl_load ##0 (dev_ptr == 16'h0001) |-> s_answer ##0
			(rsp.data == ($past(dev_load_data) | 8'hC0));
	endproperty
	property p_ext;
		s_fl_load ##0 (dev_ptr == 16'h0002) |-> s_answer ##0
			(rsp.data == ($past(dev_load_data) | 8'hF8));
	endproperty
	property p_fuse;
		s_fl_load ##0 (dev_ptr == 16'h0000 || dev_ptr == 16'h0003)
			|-> s_answer ##0 (rsp.data == $past(dev_load_data));
	endproperty
	property p_sig;
		dev_load && dev_ctrl_wdata == SPMRC_CODE_SIGNATURE_READ_SELECT |-> s_answer
			##0 (rsp.data == $past(dev_load_data));
	endproperty
	property p_done;
		rsp_valid && !rsp.err |-> !$past(dev_ctrl_rdata[0]);
	endproperty
	a_arm: assert property (p_arm) else $error("no strobe after write");
	a_ee: assert property (p_ee) else $error("write while busy");
	a_spm: assert property (p_spm) else $error("write while armed");
	a_irq: assert property (p_irq) else $error("irq not held");
	a_fl_ptr: assert property (p_fl_ptr) else $error("bad pointer");
	a_lock: assert property (p_lock) else $error("lock byte bad");
	a_ext: assert property (p_ext) else $error("ext fuse bad");
	a_fuse: assert property (p_fuse) else $error("fuse byte bad");
	a_sig: assert property (p_sig) else $error("signature bad");
	a_done: assert property (p_done) else $error("answer too early");
endmodule : spmrc_host_properties

bind spmrc_host spmrc_host_properties #(.MAX_CYC(MAX_CYC)) u_props (
	.core_clk(core_clk), .rstn(rstn), .rsp_valid(rsp_valid), .rsp(rsp),
	.irq_hold(irq_hold), .dev_ctrl_wr(dev_ctrl_wr),
	.dev_ctrl_wdata(dev_ctrl_wdata), .dev_ctrl_rdata(dev_ctrl_rdata),
	.dev_eeprom_busy(dev_eeprom_busy), .dev_ptr(dev_ptr),
	.dev_store(dev_store), .dev_load(dev_load),
	.dev_load_data(dev_load_data));

// ### dv/spmrc_dev_model.sv
/*
 * Behavioural self-programming device: control register, readback and
 * timed flash operations. Assumes strobes arrive on core_clk edges.
 */
`timescale 1ns/10ps
module spmrc_dev_model #(
	parameter int OP_CYC = 30
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic        stall,
	input  wire logic        ee_busy,
	input  wire logic        ctrl_wr,
	input  wire logic [7:0]  ctrl_wdata,
	output logic [7:0]       ctrl_rdata,
	input  wire logic [15:0] ptr,
	input  wire logic        store,
	input  wire logic        load,
	output logic [7:0]       load_data
);
	import spmrc_pkg::*;
	// ------
	// state and readback
	// ------
	// fuse and lock values are arbitrary; a zero bit means programmed
	localparam logic [7:0] FL = 8'h5E;
	localparam logic [7:0] FH = 8'hD9;
	localparam logic [7:0] LK = 8'h2B;
	localparam logic [7:0] FE = 8'h03;
	logic [7:0]  ctrl_r;
	logic [2:0]  arm_r;
	logic        rww_r;
	// flash timer ignores reset: a running write completes across it
	logic [15:0] op_r = 16'h0000;
	logic [7:0]  rd_nxt;
	wire win_ld = ctrl_r[0] && arm_r >= 3'd2;
	wire fl_sel = win_ld && ctrl_r[3];
	wire sg_sel = win_ld && ctrl_r[5];
	// signature bytes are arbitrary, derived from the address
	assign rd_nxt = fl_sel ? (ptr[1:0] == 2'd1 ? LK : ptr[1:0] == 2'd0 ? FL
		: ptr[1:0] == 2'd3 ? FH : FE) : sg_sel ? 8'hA5 ^ ptr[7:0] : ~ptr[7:0];
	assign ctrl_rdata = {ctrl_r[7], rww_r, ctrl_r[5:1],
		ctrl_r[0] | (op_r != 16'h0000)};
	// level interrupt request while the enable bit reads clear
	wire irq_lvl = !ctrl_rdata[0];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= 8'h00;
			arm_r <= 3'd0;
			rww_r <= 1'b0;
			load_data <= 8'h00;
		end else begin
			// a released data bus toggles the last byte every cycle
			load_data <= load ? rd_nxt : ~load_data;
			arm_r <= (arm_r != 3'd0) ? arm_r - 3'd1 : 3'd0;
			if (op_r > 16'h0001 && !stall)
				op_r <= op_r - 16'h0001;
			if (op_r == 16'h0001) begin
				op_r <= 16'h0000;
				ctrl_r <= 8'h00;
			end
			if (ctrl_wr && !ee_busy && !ctrl_r[0]) begin
				ctrl_r <= ctrl_wdata;
				arm_r <= 3'd4;
			end else if (store && arm_r != 3'd0) begin
				arm_r <= 3'd0;
				op_r <= (ctrl_r[2:1] != 2'b00 || ctrl_r[3]) ? 16'(OP_CYC) : 16'h1;
				rww_r <= !ctrl_r[4] && (rww_r || ctrl_r[2:1] != 2'b00);
			end else if ((load && win_ld) || arm_r == 3'd1) begin
				ctrl_r <= 8'h00;
				arm_r <= 3'd0;
			end
		end
	end
endmodule : spmrc_dev_model

// ### dv/tb_top.sv
/*
 * Bench for the host sequencer: readback, refusals, flash operations,
 * eeprom lockout and poll timeout. Assumes the device model beside it.
 */
`timescale 1ns/10ps
module tb_top;
	import spmrc_pkg::*;
	logic        core_clk, rstn, cmd_valid, cmd_ready, rsp_valid, irq_hold;
	logic        ctrl_wr, store, load, ee_busy, stall;
	logic [7:0]  ctrl_wdata, ctrl_rdata, load_data;
	logic [15:0] ptr, wdata;
	spmrc_cmd_t  cmd;
	spmrc_rsp_t  rsp;
	int          num_errors, check_count, cyc, ee_wr;
	logic [15:0] sig_a [7] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004,
		16'h000E, 16'h0012, 16'h0018};
	spmrc_op_t   ops [5] = '{SPMRC_OP_LOAD, SPMRC_OP_ERASE, SPMRC_OP_WRITE,
		SPMRC_OP_LOCK_WR, SPMRC_OP_RWW_EN};
	spmrc_host #(.MAX_CYC(50)) u_dut (
		.core_clk(core_clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
		.irq_hold(irq_hold), .dev_ctrl_wr(ctrl_wr),
		.dev_ctrl_wdata(ctrl_wdata), .dev_ctrl_rdata(ctrl_rdata),
		.dev_eeprom_busy(ee_busy), .dev_ptr(ptr), .dev_wdata(wdata),
		.dev_store(store), .dev_load(load), .dev_load_data(load_data));
	spmrc_dev_model #(.OP_CYC(30)) u_dev (
		.core_clk(core_clk), .rstn(rstn), .stall(stall), .ee_busy(ee_busy),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
		.ptr(ptr), .store(store), .load(load), .load_data(load_data));
	// ------
	// tasks
	// ------
	task automatic chk(input logic [8:0] exp, input logic [8:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic run(input spmrc_op_t op, input logic [15:0] a,
		output spmrc_rsp_t r);
		int n;
		cmd_valid = 1'b1;
		cmd = '{op, a, 16'h00FF};
		while (cmd_ready !== 1'b1) @(negedge core_clk);
		@(negedge core_clk);
		cmd_valid = 1'b0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400)
			num_errors++;
		r = rsp;
	endtask : run
	task automatic end_sim();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	// ------
	// clock, watchdog, sequence
	// ------
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc++;
		if (ctrl_wr && ee_busy)
			ee_wr++;
		if (cyc == 5000) begin
			num_errors++;
			end_sim();
		end
	end
	initial begin
		spmrc_rsp_t r;
		int         t0;
		logic       ok;
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		ee_busy = 1'b0;
		stall = 1'b0;
		repeat (2) @(negedge core_clk);
		chk(9'h100, {cmd_ready, store, load, ctrl_wr, rsp_valid, 4'h0});
		rstn = 1'b1;
		run(SPMRC_OP_LOCK_RD, 16'h0000, r);
		chk({u_dev.LK | 8'hC0, 1'b0}, r);
		run(SPMRC_OP_FUSE_LO, 16'h0000, r);
		chk({u_dev.FL, 1'b0}, r);
		run(SPMRC_OP_FUSE_HI, 16'h0000, r);
		chk({u_dev.FH, 1'b0}, r);
		run(SPMRC_OP_FUSE_EXT, 16'h0000, r);
		chk({u_dev.FE | 8'hF8, 1'b0}, r);
		foreach (sig_a[i]) begin
			run(SPMRC_OP_SIG_RD, sig_a[i], r);
			chk({8'hA5 ^ sig_a[i][7:0], 1'b0}, r);
		end
		run(SPMRC_OP_SIG_RD, 16'h0003, r);
		chk(9'h001, {8'h00, r.err});
		foreach (ops[i]) begin
			t0 = cyc;
			run(ops[i], 16'h0040, r);
			ok = (ops[i] inside {SPMRC_OP_LOAD, SPMRC_OP_RWW_EN}) || cyc - t0 > 30;
			chk(9'h002, {7'h00, ok, r.err | u_dev.rww_r});
		end
		chk(9'h0FF, wdata[8:0]);
		chk(9'h000, {1'b0, wdata[15:8]});
		ee_busy = 1'b1;
		fork
			run(SPMRC_OP_FUSE_LO, 16'h0000, r);
			begin
				repeat (20) @(negedge core_clk);
				ee_busy = 1'b0;
			end
		join
		chk({u_dev.FL, 1'b0}, r);
		chk(9'h000, 9'(ee_wr));
		stall = 1'b1;
		run(SPMRC_OP_ERASE, 16'h0080, r);
		chk(9'h001, {8'h00, r.err});
		rstn = 1'b0;
		repeat (2) @(negedge core_clk);
		rstn = 1'b1;
		stall = 1'b0;
		chk(9'h001, {8'h00, ctrl_rdata[0]});
		chk(9'h000, {8'h00, u_dev.irq_lvl});
		run(SPMRC_OP_FUSE_LO, 16'h0000, r);
		chk({u_dev.FL, 1'b0}, r);
		chk(9'h001, {8'h00, u_dev.irq_lvl});
		repeat (40) @(negedge core_clk);
		end_sim();
	end
endmodule : tb_top
